// file: timed_port_pkg.sv
`default_nettype none
package timed_port_pkg;
	localparam int NUM_CB   = 6;
	localparam int XFER_W   = 32;
	localparam int CNT_W    = 16;
	localparam int CB_DIV_W = 8;
	localparam int CLK_HZ   = 25_000_000;

	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_DATA  = 8'h04;
	localparam logic [7:0] A_COND  = 8'h08;
	localparam logic [7:0] A_TIME  = 8'h0c;
	localparam logic [7:0] A_COUNT = 8'h10;
	localparam logic [7:0] A_STAMP = 8'h14;
	localparam logic [7:0] A_ISTAT = 8'h18;
	localparam logic [7:0] A_ICLR  = 8'h1c;
	localparam logic [7:0] A_IEN   = 8'h20;
	localparam logic [7:0] A_CB1   = 8'h24;

	localparam int C_EN    = 0;
	localparam int C_DIR   = 1;
	localparam int C_OD    = 2;
	localparam int C_CEN   = 3;
	localparam int C_CNEQ  = 4;
	localparam int C_TIMED = 5;
	localparam int C_SIN   = 6;
	localparam int C_SOUT  = 7;
	localparam int C_CSEL  = 8;
	localparam int CSEL_W  = 3;
	localparam int CB_SRC  = 8;

	localparam int EV_XFER = 0;
	localparam int EV_COND = 1;
	localparam int EV_LOST = 2;
	localparam int EV_W    = 3;

	localparam logic [CSEL_W-1:0]   CLK_SEL_RST = 3'h0;
	localparam logic [CB_DIV_W-1:0] CB0_DIV     = 8'h00;
endpackage
`default_nettype wire

// file: clk_block.sv
`timescale 1ns/1ps
`default_nettype none
module clk_block #(
	parameter int DIV_W = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             src_pin_sel,
	input  wire logic [DIV_W-1:0] div,
	input  wire logic             ext_clk,
	output logic                  tick
);
	if (DIV_W < 1)
	begin : g_bad_div
		$error("clk_block: DIV_W must be at least 1");
	end

	typedef struct packed {
		logic             prev;
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} cb_state_s;

	cb_state_s s_r;
	cb_state_s s_n;
	logic      src_edge;

	always_comb
	begin
		s_n = s_r;
		s_n.prev = ext_clk;
		// Reference source advances on every pclk edge
		src_edge = src_pin_sel ? (ext_clk & ~s_r.prev) : 1'b1;
		s_n.tick = 1'b0;
		if (src_edge)
		begin
			if (s_r.cnt >= div)
			begin
				s_n.cnt = '0;
				s_n.tick = 1'b1;
			end
			else
			begin
				s_n.cnt = s_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_n;
	end

	assign tick = s_r.tick;
endmodule
`default_nettype wire

// file: timed_port.sv
// Operation
// - Port width 1/4/8/16/32, single direction
// - Drive pins or sample, optional condition wait
// - Open drain: zero pulls low, one floats
// - Data passes shift stage and transfer register
// - 16-bit counter schedules timed transfers
// - Counter stamped on transfer, live readable
// - Each register access completes in one cycle
// - Enabled link takes pins from port
// - Narrower port owns shared pins, rest usable
// - Six clock blocks, block 0 reference
// - Clock block sources 1-bit pin, divides
// - Input strobe qualifies, output strobe accompanies data
// - Reset attaches port to clock block 0
// - Unused pins get weak pull-down
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timed_port #(
	parameter int WIDTH = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe_n,
	output logic      [WIDTH-1:0] pull_dn,
	input  wire logic             strobe_in,
	output logic                  strobe_out,
	input  wire logic             clk_src_pin,
	input  wire logic             link_en,
	input  wire logic [WIDTH-1:0] narrow_claim,
	output logic                  irq
);
	localparam int NCB = timed_port_pkg::NUM_CB;
	localparam int XW  = timed_port_pkg::XFER_W;
	localparam int DW  = timed_port_pkg::CB_DIV_W;
	localparam logic [5:0] LAST = 6'(XW / WIDTH - 1);

	if (!(WIDTH == 1 || WIDTH == 4 || WIDTH == 8 || WIDTH == 16 || WIDTH == 32))
	begin : g_bad_width
		$error("timed_port: WIDTH must be 1, 4, 8, 16 or 32");
	end

	typedef struct packed {
		logic                                  en;
		logic                                  dir_out;
		logic                                  od;
		logic                                  cond_en;
		logic                                  cond_neq;
		logic                                  timed;
		logic                                  stb_in_en;
		logic                                  stb_out_en;
		logic [timed_port_pkg::CSEL_W-1:0]     clk_sel;
		logic [NCB-1:1][DW:0]                  cb_cfg;
		logic [XW-1:0]                         tr;
		logic [XW-1:0]                         sh;
		logic [XW-1:0]                         cond;
		logic                                  tr_full;
		logic [5:0]                            cnt;
		logic [timed_port_pkg::CNT_W-1:0]      count;
		logic [timed_port_pkg::CNT_W-1:0]      stamp;
		logic [timed_port_pkg::CNT_W-1:0]      time_at;
		logic [timed_port_pkg::EV_W-1:0]       ist;
		logic [timed_port_pkg::EV_W-1:0]       ien;
		logic [WIDTH-1:0]                      drv;
		logic [WIDTH-1:0]                      pin_out;
		logic [WIDTH-1:0]                      pin_oe_n;
		logic [WIDTH-1:0]                      pull_dn;
		logic                                  strobe_out;
		logic                                  irq;
		logic                                  pready;
		logic                                  pslverr;
		logic [31:0]                           prdata;
	} state_s;

	// Pins float with pull-down until software claims them
	localparam state_s ST_RST = '{pin_oe_n: '1, pull_dn: '1,
		clk_sel: timed_port_pkg::CLK_SEL_RST, default: '0};

	state_s                              s_r;
	state_s                              s_n;
	logic   [NCB-1:0]                    cb_tick;
	logic   [NCB-1:0]                    cb_src;
	logic   [NCB-1:0][DW-1:0]            cb_div;
	logic                                setup;
	logic                                wr;
	logic                                rd;
	logic                                tick;
	logic                                match;
	logic                                time_ok;
	logic                                take;
	logic   [XW-1:0]                     pins_ext;
	logic   [timed_port_pkg::EV_W-1:0]   ev;
	logic   [timed_port_pkg::EV_W-1:0]   iclr;
	logic   [WIDTH-1:0]                  own;
	logic   [31:0]                       rdata;
	logic                                hit;

	for (genvar k = 0; k < NCB; k++)
	begin : g_cb
		if (k == 0)
		begin : g_ref
			assign cb_src[k] = 1'b0;
			assign cb_div[k] = timed_port_pkg::CB0_DIV;
		end
		else
		begin : g_prog
			assign cb_src[k] = s_r.cb_cfg[k][timed_port_pkg::CB_SRC];
			assign cb_div[k] = s_r.cb_cfg[k][DW-1:0];
		end
		clk_block #(
			.DIV_W(DW)
		) u_cb (
			.pclk       (pclk),
			.presetn    (presetn),
			.src_pin_sel(cb_src[k]),
			.div        (cb_div[k]),
			.ext_clk    (clk_src_pin),
			.tick       (cb_tick[k])
		);
	end

	always_comb
	begin
		s_n = s_r;
		setup = psel & ~penable;
		wr = psel & penable & s_r.pready & pwrite;
		rd = psel & penable & s_r.pready & ~pwrite;
		tick = (32'(s_r.clk_sel) < NCB) ? cb_tick[s_r.clk_sel] : cb_tick[0];
		pins_ext = 32'(pin_in);
		ev = '0;
		iclr = '0;
		match = s_r.cond_neq ? (pin_in != s_r.cond[WIDTH-1:0])
			: (pin_in == s_r.cond[WIDTH-1:0]);
		time_ok = ~s_r.timed | (s_r.count == s_r.time_at);
		take = ~s_r.stb_in_en | strobe_in;

		// A software read of the input word clears tr_full before a same-cycle refill checks it
		if (rd && paddr == timed_port_pkg::A_DATA && !s_r.dir_out)
			s_n.tr_full = 1'b0;

		s_n.strobe_out = 1'b0;
		if (s_r.en && tick)
		begin
			s_n.count = s_r.count + 1'b1;
			if (s_r.dir_out)
			begin
				if (s_r.cnt != 6'h0)
				begin
					s_n.drv = s_r.sh[WIDTH-1:0];
					s_n.sh = s_r.sh >> WIDTH;
					s_n.cnt = s_r.cnt - 6'h1;
					s_n.strobe_out = s_r.stb_out_en;
				end
				else if (s_r.tr_full && time_ok)
				begin
					s_n.drv = s_r.tr[WIDTH-1:0];
					s_n.sh = s_r.tr >> WIDTH;
					s_n.cnt = LAST;
					s_n.tr_full = 1'b0;
					s_n.stamp = s_r.count;
					ev[timed_port_pkg::EV_XFER] = 1'b1;
					s_n.strobe_out = s_r.stb_out_en;
				end
			end
			else if (take && (s_r.cnt != 6'h0 || ((~s_r.cond_en | match) && time_ok)))
			begin
				s_n.sh = (s_r.sh >> WIDTH) | (pins_ext << (XW - WIDTH));
				if (s_r.cnt == 6'h0 && s_r.cond_en)
					ev[timed_port_pkg::EV_COND] = 1'b1;
				if (s_r.cnt == LAST)
				begin
					// Unread word is overwritten; flagged as lost
					if (s_n.tr_full)
						ev[timed_port_pkg::EV_LOST] = 1'b1;
					s_n.tr = s_n.sh;
					s_n.tr_full = 1'b1;
					s_n.cnt = 6'h0;
					s_n.stamp = s_r.count;
					ev[timed_port_pkg::EV_XFER] = 1'b1;
				end
				else
				begin
					s_n.cnt = s_r.cnt + 6'h1;
				end
			end
		end

		if (wr)
		begin
			case (paddr)
				timed_port_pkg::A_CTRL:
				begin
					s_n.en = pwdata[timed_port_pkg::C_EN];
					s_n.dir_out = pwdata[timed_port_pkg::C_DIR];
					s_n.od = pwdata[timed_port_pkg::C_OD];
					s_n.cond_en = pwdata[timed_port_pkg::C_CEN];
					s_n.cond_neq = pwdata[timed_port_pkg::C_CNEQ];
					s_n.timed = pwdata[timed_port_pkg::C_TIMED];
					s_n.stb_in_en = pwdata[timed_port_pkg::C_SIN];
					s_n.stb_out_en = pwdata[timed_port_pkg::C_SOUT];
					if (32'(pwdata[timed_port_pkg::C_CSEL +: timed_port_pkg::CSEL_W]) < NCB)
						s_n.clk_sel = pwdata[timed_port_pkg::C_CSEL +: timed_port_pkg::CSEL_W];
					// Half-shifted word would mix directions
					s_n.cnt = 6'h0;
				end
				timed_port_pkg::A_DATA:
				begin
					if (s_r.dir_out)
					begin
						if (s_n.tr_full)
							ev[timed_port_pkg::EV_LOST] = 1'b1;
						s_n.tr = pwdata;
						s_n.tr_full = 1'b1;
					end
				end
				timed_port_pkg::A_COND: s_n.cond = pwdata;
				timed_port_pkg::A_TIME: s_n.time_at = pwdata[timed_port_pkg::CNT_W-1:0];
				timed_port_pkg::A_ICLR: iclr = pwdata[timed_port_pkg::EV_W-1:0];
				timed_port_pkg::A_IEN: s_n.ien = pwdata[timed_port_pkg::EV_W-1:0];
				default:
				begin
					for (int k = 1; k < NCB; k++)
					begin
						if (paddr == timed_port_pkg::A_CB1 + 8'(4 * (k - 1)))
							s_n.cb_cfg[k] = pwdata[DW:0];
					end
				end
			endcase
		end

		// Set beats clear in the same cycle
		s_n.ist = (s_r.ist & ~iclr) | ev;
		s_n.irq = |(s_n.ist & s_n.ien);

		// Read data is latched in setup so access ends in its first cycle
		rdata = '0;
		hit = 1'b1;
		case (paddr)
			timed_port_pkg::A_CTRL:
			begin
				rdata[timed_port_pkg::C_EN] = s_r.en;
				rdata[timed_port_pkg::C_DIR] = s_r.dir_out;
				rdata[timed_port_pkg::C_OD] = s_r.od;
				rdata[timed_port_pkg::C_CEN] = s_r.cond_en;
				rdata[timed_port_pkg::C_CNEQ] = s_r.cond_neq;
				rdata[timed_port_pkg::C_TIMED] = s_r.timed;
				rdata[timed_port_pkg::C_SIN] = s_r.stb_in_en;
				rdata[timed_port_pkg::C_SOUT] = s_r.stb_out_en;
				rdata[timed_port_pkg::C_CSEL +: timed_port_pkg::CSEL_W] = s_r.clk_sel;
			end
			timed_port_pkg::A_DATA: rdata = s_r.tr;
			timed_port_pkg::A_COND: rdata = s_r.cond;
			timed_port_pkg::A_TIME: rdata = 32'(s_r.time_at);
			timed_port_pkg::A_COUNT: rdata = 32'(s_r.count);
			timed_port_pkg::A_STAMP: rdata = 32'(s_r.stamp);
			timed_port_pkg::A_ISTAT: rdata = 32'(s_r.ist);
			timed_port_pkg::A_ICLR: rdata = '0;
			timed_port_pkg::A_IEN: rdata = 32'(s_r.ien);
			default:
			begin
				hit = 1'b0;
				for (int k = 1; k < NCB; k++)
				begin
					if (paddr == timed_port_pkg::A_CB1 + 8'(4 * (k - 1)))
					begin
						rdata = 32'(s_r.cb_cfg[k]);
						hit = 1'b1;
					end
				end
			end
		endcase
		s_n.pready = setup;
		s_n.pslverr = setup & ~hit;
		if (setup)
			s_n.prdata = hit ? rdata : '0;

		own = {WIDTH{s_n.en & ~link_en}} & ~narrow_claim;
		s_n.pin_out = s_n.od ? '0 : s_n.drv;
		s_n.pin_oe_n = ~(own & {WIDTH{s_n.dir_out}} & (s_n.od ? ~s_n.drv : '1));
		s_n.pull_dn = ~own;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_r <= ST_RST;
		else
			s_r <= s_n;
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign pin_out = s_r.pin_out;
	assign pin_oe_n = s_r.pin_oe_n;
	assign pull_dn = s_r.pull_dn;
	assign strobe_out = s_r.strobe_out;
	assign irq = s_r.irq;

	default clocking dflt_clk @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_dir_single: assert property ((~pin_oe_n != '0) |-> s_r.dir_out)
		else $error("input port drives a pin");
	a_od_never_high: assert property (s_r.od |-> ((~pin_oe_n & pin_out) == '0))
		else $error("open drain pin driven high");
	a_apb_one_cycle: assert property (psel && !penable |=> pready)
		else $error("register access not answered in one cycle");
	a_link_release: assert property (link_en |=> (&pin_oe_n && &pull_dn))
		else $error("port still drives pins during link");
	a_narrow_wins: assert property (1'b1 |=> (($past(narrow_claim) & ~pin_oe_n) == '0))
		else $error("claimed pin driven by wide port");
	a_count_step: assert property (s_r.en && tick |=> s_r.count == $past(s_r.count) + 16'h1)
		else $error("port counter did not advance");
	a_stamp_taken: assert property (ev[timed_port_pkg::EV_XFER] |=> s_r.stamp == $past(s_r.count))
		else $error("timestamp not captured");
	a_timed_hold: assert property (s_r.dir_out && s_r.timed && s_r.tr_full && s_r.cnt == 6'h0
		&& s_r.count != s_r.time_at && !wr |=> s_r.tr_full)
		else $error("timed output left early");
	a_unused_pull: assert property (!s_r.en |-> &pull_dn ##1 1'b1)
		else $error("disabled port without pull-down");
	a_event_irq: assert property ((ev & s_r.ien) != '0 |=> irq ##1 (irq || $past(wr)))
		else $error("enabled event did not raise interrupt");
	a_strobe_data: assert property (strobe_out |-> $past(s_r.dir_out && s_r.stb_out_en))
		else $error("output strobe without output data");
endmodule
`default_nettype wire

// file: ext_hw.sv
`timescale 1ns/1ps
`default_nettype none
module ext_hw #(
	parameter int W = 4
) (
	input  wire logic         pclk,
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe_n,
	input  wire logic         strobe_out,
	input  wire logic [W-1:0] drv_val,
	input  wire logic         drv_en,
	output logic      [W-1:0] pin_in,
	output logic      [31:0]  rx_word,
	output var int            rx_cnt
);
	// Released lines float up through the board pull-up
	always_comb
		for (int i = 0; i < W; i++)
			pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (drv_en ? drv_val[i] : 1'b1);
	initial rx_cnt = 0;
	// Chunks arrive low bits first, one per strobe
	always @(posedge pclk)
		if (strobe_out === 1'b1)
		begin
			rx_word <= {pin_in, rx_word[31:W]};
			rx_cnt  <= rx_cnt + 1;
		end
endmodule
`default_nettype wire

// file: timed_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timed_port_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        strobe_in, strobe_out, clk_src_pin, link_en, irq, drv_en, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, rx_word, c1;
	logic [3:0]  pin_in, pin_out, pin_oe_n, pull_dn, narrow_claim, drv_val;
	logic [15:0] t;
	int          rx_cnt, num_errors, total_checks, acc, n0;

	timed_port i_timed_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pull_dn(pull_dn), .strobe_in(strobe_in), .strobe_out(strobe_out),
		.clk_src_pin(clk_src_pin), .link_en(link_en), .narrow_claim(narrow_claim), .irq(irq));
	ext_hw i_ext_hw (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.strobe_out(strobe_out), .drv_val(drv_val), .drv_en(drv_en), .pin_in(pin_in),
		.rx_word(rx_word), .rx_cnt(rx_cnt));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic tally_and_finish();
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Master holds the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		acc = 0;
		// Idle edge keeps back-to-back calls from re-driving psel in one step
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			acc++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cy(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic wait_rx(input int n);
		repeat (300) if (rx_cnt < n) @(posedge pclk);
	endtask

	task automatic src_toggle(input int n);
		repeat (n)
		begin
			cy(3);
			clk_src_pin <= ~clk_src_pin;
		end
		cy(6);
	endtask

	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		tally_and_finish();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, strobe_in, clk_src_pin, link_en, drv_en} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		narrow_claim = 4'h0;
		drv_val = 4'h0;
		num_errors = 0;
		total_checks = 0;
		cy(20);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'(pin_oe_n), 32'hf);
		chk(32'(pull_dn), 32'hf);
		chk(32'({pin_out, irq}), 32'h0);
		apb(1'b0, timed_port_pkg::A_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk(32'(acc), 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(er), 32'h1);
		// Output word, LSB chunk first, with strobe and event
		apb(1'b1, timed_port_pkg::A_IEN, 32'h1);
		apb(1'b1, timed_port_pkg::A_CTRL, 32'h83);
		apb(1'b1, timed_port_pkg::A_DATA, 32'h87654321);
		wait_rx(8);
		chk(rx_word, 32'h87654321);
		chk(32'(rx_cnt), 32'h8);
		chk(32'(irq), 32'h1);
		apb(1'b0, timed_port_pkg::A_ISTAT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, timed_port_pkg::A_ICLR, 32'h7);
		cy(2);
		chk(32'(irq), 32'h0);
		narrow_claim <= 4'h3;
		cy(3);
		chk(32'(pin_oe_n), 32'h3);
		chk(32'(pull_dn), 32'h3);
		link_en <= 1'b1;
		cy(3);
		chk(32'(pin_oe_n), 32'hf);
		{link_en, narrow_claim} <= 5'h0;
		// Open drain: ones float and are pulled up
		n0 = rx_cnt;
		apb(1'b1, timed_port_pkg::A_CTRL, 32'h87);
		apb(1'b1, timed_port_pkg::A_DATA, 32'h0f5ac3a5);
		wait_rx(n0 + 8);
		chk(rx_word, 32'h0f5ac3a5);
		chk(32'(pin_out), 32'h0);
		// Live counter, then a timed transfer with overwrite
		apb(1'b0, timed_port_pkg::A_COUNT, 32'h0);
		c1 = rd;
		apb(1'b0, timed_port_pkg::A_COUNT, 32'h0);
		chk(32'(rd[15:0] - c1[15:0]), 32'h3);
		apb(1'b1, timed_port_pkg::A_CTRL, 32'ha3);
		apb(1'b0, timed_port_pkg::A_COUNT, 32'h0);
		t = rd[15:0] + 16'h0040;
		n0 = rx_cnt;
		apb(1'b1, timed_port_pkg::A_TIME, 32'(t));
		apb(1'b1, timed_port_pkg::A_ICLR, 32'h7);
		apb(1'b1, timed_port_pkg::A_DATA, 32'h11111111);
		apb(1'b1, timed_port_pkg::A_DATA, 32'h2468ace0);
		chk(32'(rx_cnt), 32'(n0));
		apb(1'b0, timed_port_pkg::A_ISTAT, 32'h0);
		chk(32'(rd[2]), 32'h1);
		wait_rx(n0 + 8);
		chk(rx_word, 32'h2468ace0);
		apb(1'b0, timed_port_pkg::A_STAMP, 32'h0);
		chk(32'(rd[15:0]), 32'(t));
		// Input waits for the pin condition
		drv_en  <= 1'b1;
		drv_val <= 4'h3;
		apb(1'b1, timed_port_pkg::A_COND, 32'h7);
		apb(1'b1, timed_port_pkg::A_CTRL, 32'h09);
		apb(1'b1, timed_port_pkg::A_ICLR, 32'h7);
		cy(20);
		apb(1'b0, timed_port_pkg::A_ISTAT, 32'h0);
		chk(32'(rd[1:0]), 32'h0);
		drv_val <= 4'h7;
		cy(20);
		apb(1'b0, timed_port_pkg::A_ISTAT, 32'h0);
		chk(32'(rd[1:0]), 32'h3);
		apb(1'b0, timed_port_pkg::A_DATA, 32'h0);
		chk(rd, 32'h77777777);
		// Not-equal condition starts only once the pins differ
		apb(1'b1, timed_port_pkg::A_CTRL, 32'h19);
		apb(1'b1, timed_port_pkg::A_ICLR, 32'h7);
		cy(20);
		apb(1'b0, timed_port_pkg::A_ISTAT, 32'h0);
		chk(32'(rd[1:0]), 32'h0);
		drv_val <= 4'h5;
		cy(20);
		apb(1'b0, timed_port_pkg::A_ISTAT, 32'h0);
		chk(32'(rd[1:0]), 32'h3);
		// Input strobe qualifies samples
		apb(1'b1, timed_port_pkg::A_CTRL, 32'h41);
		apb(1'b1, timed_port_pkg::A_ICLR, 32'h7);
		cy(20);
		apb(1'b0, timed_port_pkg::A_ISTAT, 32'h0);
		chk(32'(rd[0]), 32'h0);
		strobe_in <= 1'b1;
		cy(20);
		apb(1'b0, timed_port_pkg::A_ISTAT, 32'h0);
		chk(32'(rd[0]), 32'h1);
		// Clock block 1 paced by the source pin
		drv_en <= 1'b0;
		apb(1'b1, timed_port_pkg::A_CB1, 32'h100);
		apb(1'b1, timed_port_pkg::A_CTRL, 32'h183);
		n0 = rx_cnt;
		apb(1'b1, timed_port_pkg::A_DATA, 32'h9abcdef1);
		cy(20);
		chk(32'(rx_cnt), 32'(n0));
		src_toggle(16);
		chk(32'(rx_cnt), 32'(n0 + 8));
		chk(rx_word, 32'h9abcdef1);
		// Divide by two: eight source edges give four chunks
		apb(1'b1, timed_port_pkg::A_CB1, 32'h101);
		n0 = rx_cnt;
		apb(1'b1, timed_port_pkg::A_DATA, 32'h13579bdf);
		src_toggle(16);
		chk(32'(rx_cnt), 32'(n0 + 4));
		src_toggle(16);
		chk(32'(rx_cnt), 32'(n0 + 8));
		chk(rx_word, 32'h13579bdf);
		tally_and_finish();
	end
endmodule
`default_nettype wire
